// *** hdl/vstg_params.svh ***
/*
  Constants of the video sync timing generator: register offsets,
  field positions, reset values and fixed offsets of the timing fields.
  Assumes byte addresses on an 8-bit register port, 32-bit data.
*/
`ifndef VSTG_PARAMS_SVH
`define VSTG_PARAMS_SVH

// Register byte offsets
`define VSTG_A_HSYNC   8'h00
`define VSTG_A_VSYNC   8'h04
`define VSTG_A_PORCH   8'h08
`define VSTG_A_SCREEN  8'h0C
`define VSTG_A_RETRACE 8'h10
`define VSTG_A_IRQCTL  8'h14
`define VSTG_A_INIT0   8'h18
`define VSTG_A_INIT1   8'h1C
`define VSTG_A_CTABLE  8'h20
`define VSTG_A_STATUS  8'h24
`define VSTG_A_MASK    8'h28

// Field positions: low field at 0, high field at 16
`define VSTG_LO_LSB    0
`define VSTG_HI_LSB    16
`define VSTG_VRST_BIT  8
`define VSTG_M800_BIT  0
`define VSTG_CIDX_LSB  24

// Fixed offsets of the timing fields
`define VSTG_HS_EXTRA  1
`define VSTG_HBP_EXTRA 2

// Memory mode limits
`define VSTG_W640      640
`define VSTG_H640      480
`define VSTG_W800      800
`define VSTG_H800      600

// Reset values
`define VSTG_RST_TIME  12'h000
`define VSTG_RST_VRST  1'b0
`define VSTG_RST_M800  1'b0
`endif

// *** hdl/vstg_pkg.sv ***
/*
  Types of the video sync timing generator.
  Assumes the constants header is compiled alongside.
*/
package vstg_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } vstg_req_t;

  typedef struct packed {
    logic        hsync;
    logic        vsync;
    logic        blank;
    logic [23:0] rgb;
  } vstg_video_t;

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic [13:0] h;
    logic [13:0] v;
    logic        hsync;
    logic        vsync;
    logic        blank;
    logic [23:0] rgb;
    logic [11:0] hs_on;
    logic [11:0] hs_off;
    logic [11:0] vs_on;
    logic [11:0] vs_off;
    logic [11:0] hbp;
    logic [11:0] vbp;
    logic [11:0] wid;
    logic [11:0] hgt;
    logic [11:0] irq_line;
    logic        m800;
    logic        vrst;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [31:0] rdata;
  } vstg_state_t;
endpackage

// *** hdl/vstg_top.sv ***
/*
  Video sync timing generator: sync and blank from programmed sync,
  porch and screen size values, line counter readback, line interrupt
  and a color lookup table.
  Assumes dot_clock_in is a free running clock far slower than clk_in
  (at least four clk_in periods per dot clock), sampled here.
*/
`timescale 1ns/1ps
`include "vstg_params.svh"

module vstg_top
  import vstg_pkg::*;
#(
  parameter int CIDX_W = 6
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        dot_clock_in,
  input  wire vstg_req_t   bus_in,
  input  wire logic [CIDX_W-1:0] pix_index_in,
  output logic [31:0]      rdata_out,
  output logic             irq_out,
  output vstg_video_t      video_out
);

  localparam int CW = 14;

  vstg_state_t st;
  vstg_state_t next_st;

  logic [23:0]   ctab [2**CIDX_W];
  logic          tick;
  logic          line_end;
  logic          frame_end;
  logic          hact;
  logic          vact;
  logic          ct_we;
  logic [1:0]    ev;
  logic [1:0]    w1c;
  logic [CW-1:0] h_last;
  logic [CW-1:0] v_len;
  logic [CW-1:0] h_beg;
  logic [CW-1:0] h_end;
  logic [CW-1:0] v_beg;
  logic [CW-1:0] v_end;
  logic [11:0]   act_w;
  logic [11:0]   act_h;
  logic [11:0]   lim_w;
  logic [11:0]   lim_h;
  logic [11:0]   voff;
  logic [11:0]   next_voff;
  logic [CIDX_W-1:0] ct_idx;

  // ****************************************************************
  // Derived timing limits
  // ****************************************************************

  always_comb begin
    // Line length: both sync phases, each one longer than its field
    h_last = CW'(st.hs_on) + CW'(st.hs_off)
           + CW'(2 * `VSTG_HS_EXTRA - 1);
    // Frame length in lines, no offset on either phase
    v_len  = CW'(st.vs_on) + CW'(st.vs_off);
    lim_w  = st.m800 ? 12'(`VSTG_W800) : 12'(`VSTG_W640);
    lim_h  = st.m800 ? 12'(`VSTG_H800) : 12'(`VSTG_H640);
    // Smaller sizes are taken as given, larger ones are cut to the mode
    act_w  = (st.wid > lim_w) ? lim_w : st.wid;
    act_h  = (st.hgt > lim_h) ? lim_h : st.hgt;
    h_beg  = CW'(st.hs_on) + CW'(`VSTG_HS_EXTRA)
           + CW'(st.hbp) + CW'(`VSTG_HBP_EXTRA);
    h_end  = h_beg + CW'(act_w);
    v_beg  = CW'(st.vs_on) + CW'(st.vbp);
    v_end  = v_beg + CW'(act_h);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb begin
    next_st = st;
    // Dot clock passes two flops, the third only feeds the edge finder
    next_st.s1 = dot_clock_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    tick      = st.s2 & ~st.s3;
    line_end  = tick && (st.h >= h_last);
    frame_end = line_end && ((st.v + CW'(1)) >= v_len);

    // Software video reset also parks the raster at its origin
    if (st.vrst) begin
      next_st.h = '0;
      next_st.v = '0;
    end else if (tick) begin
      next_st.h = line_end ? '0 : st.h + CW'(1);
      if (line_end) begin
        next_st.v = frame_end ? '0 : st.v + CW'(1);
      end
    end

    next_st.hsync = next_st.h <= CW'(st.hs_on);
    next_st.vsync = next_st.v < CW'(st.vs_on);
    hact = (next_st.h >= h_beg) && (next_st.h < h_end);
    vact = (next_st.v >= v_beg) && (next_st.v < v_end);
    next_st.blank = !(hact && vact);

    // Sync-off line counter: lines since vertical sync went inactive
    voff      = (st.v >= CW'(st.vs_on)) ? 12'(st.v - CW'(st.vs_on)) : 12'h000;
    next_voff = (next_st.v >= CW'(st.vs_on))
              ? 12'(next_st.v - CW'(st.vs_on)) : 12'h000;

    ev[0] = line_end && !st.vrst && !next_st.vsync
          && (next_voff == st.irq_line);
    ev[1] = frame_end && !st.vrst;

    next_st.rgb = next_st.blank ? 24'h000000 : ctab[pix_index_in];

    // Register writes
    w1c   = 2'b00;
    ct_we = 1'b0;
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        `VSTG_A_HSYNC: begin
          next_st.hs_on  = bus_in.wdata[`VSTG_LO_LSB +: 12];
          next_st.hs_off = bus_in.wdata[`VSTG_HI_LSB +: 12];
        end
        `VSTG_A_VSYNC: begin
          next_st.vs_on  = bus_in.wdata[`VSTG_LO_LSB +: 12];
          next_st.vs_off = bus_in.wdata[`VSTG_HI_LSB +: 12];
        end
        `VSTG_A_PORCH: begin
          next_st.hbp = bus_in.wdata[`VSTG_LO_LSB +: 12];
          next_st.vbp = bus_in.wdata[`VSTG_HI_LSB +: 12];
        end
        `VSTG_A_SCREEN: begin
          next_st.wid = bus_in.wdata[`VSTG_LO_LSB +: 12];
          next_st.hgt = bus_in.wdata[`VSTG_HI_LSB +: 12];
        end
        `VSTG_A_IRQCTL: begin
          next_st.irq_line = bus_in.wdata[`VSTG_HI_LSB +: 12];
        end
        `VSTG_A_INIT0: begin
          next_st.m800 = bus_in.wdata[`VSTG_M800_BIT];
        end
        `VSTG_A_INIT1: begin
          next_st.vrst = bus_in.wdata[`VSTG_VRST_BIT];
        end
        `VSTG_A_CTABLE: begin
          ct_we = !st.vrst;
        end
        `VSTG_A_STATUS: begin
          w1c = bus_in.wdata[1:0];
        end
        `VSTG_A_MASK: begin
          next_st.mask = bus_in.wdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // A new event wins over a clear in the same cycle
    next_st.status = (st.status & ~w1c) | ev;

    // Register reads; unmapped offsets read zero
    next_st.rdata = 32'h00000000;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        `VSTG_A_HSYNC:   next_st.rdata = {4'h0, st.hs_off, 4'h0, st.hs_on};
        `VSTG_A_VSYNC:   next_st.rdata = {4'h0, st.vs_off, 4'h0, st.vs_on};
        `VSTG_A_PORCH:   next_st.rdata = {4'h0, st.vbp, 4'h0, st.hbp};
        `VSTG_A_SCREEN:  next_st.rdata = {4'h0, st.hgt, 4'h0, st.wid};
        `VSTG_A_RETRACE: next_st.rdata = {20'h00000, voff};
        `VSTG_A_IRQCTL:  next_st.rdata = {4'h0, st.irq_line, 16'h0000};
        `VSTG_A_INIT0:   next_st.rdata = {31'h00000000, st.m800};
        `VSTG_A_INIT1:   next_st.rdata = {23'h000000, st.vrst, 8'h00};
        `VSTG_A_STATUS:  next_st.rdata = {30'h00000000, st.status};
        `VSTG_A_MASK:    next_st.rdata = {30'h00000000, st.mask};
        default:         next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st          <= '0;
      st.blank    <= 1'b1;
      st.hs_on    <= `VSTG_RST_TIME;
      st.hs_off   <= `VSTG_RST_TIME;
      st.vs_on    <= `VSTG_RST_TIME;
      st.vs_off   <= `VSTG_RST_TIME;
      st.vrst     <= `VSTG_RST_VRST;
      st.m800     <= `VSTG_RST_M800;
    end else begin
      st <= next_st;
    end
  end

  // Table contents are not reset; software loads them after reset
  always_ff @(posedge clk_in) begin
    if (ct_we) begin
      ctab[bus_in.wdata[`VSTG_CIDX_LSB +: CIDX_W]] <= bus_in.wdata[23:0];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign rdata_out       = st.rdata;
  assign irq_out         = |(st.status & st.mask);
  assign video_out.hsync = st.hsync;
  assign video_out.vsync = st.vsync;
  assign video_out.blank = st.blank;
  assign video_out.rgb   = st.rgb;

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // Table index of the write on the bus, for the table checks
  assign ct_idx = bus_in.wdata[`VSTG_CIDX_LSB +: CIDX_W];

  a_hsync_end: assert property (
    (tick && !st.vrst && st.h == CW'(st.hs_on) && st.h < h_last
      && !bus_in.wr) |=> !st.hsync
  ) else $error("hsync not ended after sync-on plus one dot clock");

  a_hsync_start: assert property (
    (line_end && !st.vrst && !bus_in.wr) |=> (st.h == '0 && st.hsync)
  ) else $error("hsync not restarted at line end");

  a_line_step: assert property (
    (line_end && !st.vrst && !frame_end && !bus_in.wr)
      |=> (st.v == $past(st.v) + CW'(1))
  ) else $error("line counter did not step at line end");

  a_line_hold: assert property (
    (!line_end && !st.vrst) |=> (st.v == $past(st.v))
  ) else $error("line counter moved inside a line");

  a_vsync_start: assert property (
    (frame_end && !st.vrst && st.vs_on != 12'h000 && !bus_in.wr)
      |=> (st.v == '0 && st.vsync)
  ) else $error("vsync not raised at frame start");

  a_vsync_count: assert property (
    (line_end && !st.vrst && !bus_in.wr && st.v + CW'(1) == CW'(st.vs_on)
      && !frame_end) |=> !st.vsync
  ) else $error("vsync not released after sync-on lines");

  a_hblank_lead: assert property (
    (tick && !st.vrst && !bus_in.wr && st.h + CW'(1) == h_beg
      && st.h < h_last) |=> (st.h == h_beg)
  ) else $error("active start not after porch plus two");

  a_blank_act: assert property (
    !st.blank |-> (!st.hsync && !st.vsync)
  ) else $error("blank released during sync");

  a_blank_vbp: assert property (
    (!st.blank && !$past(bus_in.wr)) |-> (st.v >= CW'(st.vs_on) + CW'(st.vbp))
  ) else $error("blank released inside vertical back porch");

  a_line_irq: assert property (
    (ev[0] && st.mask[0]) |=> (st.status[0] && irq_out)
  ) else $error("line match did not raise interrupt");

  a_retrace_rd: assert property (
    (bus_in.rd && bus_in.addr == `VSTG_A_RETRACE)
      |=> (rdata_out == {20'h00000, $past(voff)})
  ) else $error("retrace readback differs from line counter");

  a_ctab_gate: assert property (
    (bus_in.wr && bus_in.addr == `VSTG_A_CTABLE) |-> (ct_we == !st.vrst)
  ) else $error("color table write gate wrong");

  // ****************************************************************
  // Checks on active region ends, size limits, flags, readback and table
  // ****************************************************************

  a_hblank_end: assert property (
    (tick && !st.vrst && !bus_in.wr && !st.blank && st.h + CW'(1) == h_end)
      |=> st.blank
  ) else $error("blank not raised after active width");

  a_vblank_end: assert property (
    (line_end && !st.vrst && !bus_in.wr && !frame_end && st.v + CW'(1) == v_end)
      |=> st.blank
  ) else $error("blank not raised below active height");

  // A write moves the limits, so the cycle right after one is skipped
  a_width_clip: assert property (
    (!st.blank && !$past(bus_in.wr)) |-> (st.h < h_beg + CW'(lim_w))
  ) else $error("active width beyond mode limit");

  a_height_clip: assert property (
    (!st.blank && !$past(bus_in.wr)) |-> (st.v < v_beg + CW'(lim_h))
  ) else $error("active height beyond mode limit");

  a_status_hold: assert property (
    (st.status[0] && !(bus_in.wr && bus_in.addr == `VSTG_A_STATUS && bus_in.wdata[0]))
      |=> st.status[0]
  ) else $error("line match flag lost without a clear");

  a_status_clear: assert property (
    (bus_in.wr && bus_in.addr == `VSTG_A_STATUS && bus_in.wdata[0] && !ev[0])
      |=> !st.status[0]
  ) else $error("line match flag not cleared by write of one");

  a_set_wins: assert property (
    ev[0] |=> st.status[0]
  ) else $error("line match event lost");

  a_frame_flag: assert property (
    (frame_end && !st.vrst) |=> st.status[1]
  ) else $error("frame end flag not set");

  a_rd_idle: assert property (
    !bus_in.rd |=> (rdata_out == 32'h00000000)
  ) else $error("read data not cleared after its cycle");

  a_retrace_step: assert property (
    (line_end && !st.vrst && !bus_in.wr && !frame_end && st.v >= CW'(st.vs_on))
      |=> (voff == $past(voff) + 12'h001)
  ) else $error("sync-off line counter did not step");

  a_ctab_load: assert property (
    ct_we |=> (ctab[$past(ct_idx)] == $past(bus_in.wdata[23:0]))
  ) else $error("color table entry not loaded");

  a_ctab_keep: assert property (
    (bus_in.wr && bus_in.addr == `VSTG_A_CTABLE && st.vrst)
      |=> (ctab[$past(ct_idx)] == $past(ctab[ct_idx]))
  ) else $error("color table changed while video reset set");

endmodule

// *** verif/vstg_monitor.sv ***
/*
  Monitor model at the far side of the video outputs: measures sync,
  porch and active lengths in clk_in cycles.
  Assumes the dot clock period is an exact multiple of clk_in.
*/
`timescale 1ns/1ps

module vstg_monitor
  import vstg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire vstg_video_t video_in,
  output logic [31:0]      hs_hi_out,
  output logic [31:0]      hs_lo_out,
  output logic [31:0]      vs_hi_out,
  output logic [31:0]      vs_lo_out,
  output logic [31:0]      lead_out,
  output logic [31:0]      vlead_out,
  output logic [31:0]      act_out,
  output logic [31:0]      bad_out
);
  vstg_video_t prev;
  logic [31:0] hcnt, vcnt, lcnt, fcnt, acnt;
  logic        armed;

  initial begin
    bad_out = '0;
    armed = 1'b0;
  end

  // ****************
  // Edge measurement
  // ****************
  always @(posedge clk_in) begin
    prev <= video_in;
    hcnt <= (video_in.hsync !== prev.hsync) ? 32'h1 : hcnt + 32'h1;
    vcnt <= (video_in.vsync !== prev.vsync) ? 32'h1 : vcnt + 32'h1;
    lcnt <= (prev.hsync && !video_in.hsync) ? 32'h1 : lcnt + 32'h1;
    fcnt <= (prev.vsync && !video_in.vsync) ? 32'h1 : fcnt + 32'h1;
    acnt <= (video_in.vsync && !prev.vsync) ? 32'h0 : acnt + {31'h0, !video_in.blank};
    if (video_in.hsync !== prev.hsync) begin
      if (prev.hsync) hs_hi_out <= hcnt;
      else hs_lo_out <= hcnt;
    end
    if (video_in.vsync !== prev.vsync) begin
      if (prev.vsync) vs_hi_out <= vcnt;
      else vs_lo_out <= vcnt;
    end
    // Only the first active pixel after vsync marks the vertical lead
    if (prev.blank && !video_in.blank) begin
      lead_out <= lcnt;
      if (armed) vlead_out <= fcnt;
      armed <= 1'b0;
    end
    if (prev.vsync && !video_in.vsync) armed <= 1'b1;
    if (video_in.vsync && !prev.vsync) act_out <= acnt;
    if (!video_in.blank && (video_in.hsync || video_in.vsync)) bad_out <= bad_out + 32'h1;
  end
endmodule

// *** verif/tb.sv ***
/*
  Bench of the video sync timing generator: programs timing, checks
  lengths via the monitor, line interrupt, readback and color table.
  Assumes package and constants header are compiled first.
*/
`timescale 1ns/1ps
`include "vstg_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
  import vstg_pkg::*;
  logic        clk_in, rst_in, dot_clk, irq;
  vstg_req_t   bus;
  logic [5:0]  pix_idx;
  logic [31:0] rdata, got, hs_hi, hs_lo, vs_hi, vs_lo, lead, vlead, act, bad;
  vstg_video_t video;
  int          err_total, checks, cyc, seed;
  int unsigned hs_on, line;
  logic [23:0] rgb_a;

  vstg_top #(.CIDX_W(6)) vstg_top_inst (.clk_in(clk_in), .rst_in(rst_in),
    .dot_clock_in(dot_clk), .bus_in(bus), .pix_index_in(pix_idx), .rdata_out(rdata),
    .irq_out(irq), .video_out(video));
  vstg_monitor vstg_monitor_inst (.clk_in(clk_in), .video_in(video), .hs_hi_out(hs_hi),
    .hs_lo_out(hs_lo), .vs_hi_out(vs_hi), .vs_lo_out(vs_lo), .lead_out(lead),
    .vlead_out(vlead), .act_out(act), .bad_out(bad));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Phase offset keeps the dot clock edges away from the clk_in edges
  initial begin
    dot_clk = 1'b0;
    #3;
    forever #80 dot_clk = ~dot_clk;
  end

  // *********
  // Bus tasks
  // *********
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_in);
    bus <= '0;
    @(posedge clk_in);
    got = rdata;
  endtask
  // Waits for a fresh active region so the table lookup is current
  task automatic active_rgb();
    @(posedge clk_in);
    while (video.blank !== 1'b1) @(posedge clk_in);
    while (video.blank !== 1'b0) @(posedge clk_in);
    got = {8'h0, video.rgb};
  endtask
  task automatic end_sim();
    $display("err_total %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cycles of one scan line: each sync phase is its field plus one dot clock
  function automatic int unsigned line_cyc(input int unsigned on, input int unsigned off);
    return (on + 1 + off + 1) * 32;
  endfunction

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    rst_in = 1'b1;
    bus = '0;
    pix_idx = '0;
    seed = 32'hAEB6;
    err_total = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    @(posedge clk_in);
    `CHK({irq, video.blank, rdata}, {2'b01, 32'h0})
    hs_on = 1 + ({$random(seed)} % 3);
    pix_idx <= 6'($random(seed));
    wr(`VSTG_A_HSYNC, {4'h0, 12'h8, 4'h0, 12'(hs_on)});
    wr(`VSTG_A_VSYNC, {4'h0, 12'h4, 4'h0, 12'h2});
    wr(`VSTG_A_PORCH, {4'h0, 12'h1, 4'h0, 12'h1});
    wr(`VSTG_A_SCREEN, {4'h0, 12'h2, 4'h0, 12'h3});
    line = line_cyc(hs_on, 8);
    repeat (3) @(posedge video.vsync);
    repeat (3) @(posedge clk_in);
    `CHK(hs_hi, (hs_on + 1) * 32)
    `CHK(hs_lo, 9 * 32)
    `CHK(vs_hi, 2 * line)
    `CHK(vs_lo, 4 * line)
    `CHK(lead, 3 * 32)
    `CHK(vlead, line + (hs_on + 4) * 32)
    `CHK(act, 3 * 2 * 32)
    `CHK(bad, 32'h0)
    wr(`VSTG_A_IRQCTL, {4'h0, 12'h2, 16'h0});
    wr(`VSTG_A_STATUS, 32'h3);
    wr(`VSTG_A_MASK, 32'h1);
    while (irq !== 1'b1) @(posedge clk_in);
    rd(`VSTG_A_RETRACE);
    `CHK(got, 32'h2)
    wr(`VSTG_A_STATUS, 32'h1);
    @(posedge clk_in);
    `CHK(irq, 1'b0)
    wr(`VSTG_A_MASK, 32'h0);
    repeat (2) @(posedge video.vsync);
    `CHK(irq, 1'b0)
    rd(`VSTG_A_STATUS);
    `CHK(got[0], 1'b1)
    rd(8'h30);
    `CHK(got, 32'h0)
    rgb_a = 24'($random(seed));
    wr(`VSTG_A_CTABLE, {2'b00, pix_idx, rgb_a});
    active_rgb();
    `CHK(got, {8'h0, rgb_a})
    wr(`VSTG_A_INIT1, 32'h100);
    wr(`VSTG_A_CTABLE, {2'b00, pix_idx, ~rgb_a});
    wr(`VSTG_A_INIT1, 32'h0);
    active_rgb();
    `CHK(got, {8'h0, rgb_a})
    wr(`VSTG_A_CTABLE, {2'b00, pix_idx, ~rgb_a});
    active_rgb();
    `CHK(got, {8'h0, ~rgb_a})
    wr(`VSTG_A_INIT0, 32'h1);
    rd(`VSTG_A_INIT0);
    `CHK(got, 32'h1)
    end_sim();
  end
endmodule
